//--- src/wbo_pkg.sv
// package: commands, responses, block states and sizes for block ownership
`default_nettype none
package wbo_pkg;
	localparam int ADDR_W     = 12;   // command address width
	localparam int BLOCKS     = 16;   // blocks modelled in memory
	localparam int BLK_IDX_W  = 4;
	localparam int BYTES      = 32;   // bytes per block
	localparam int ID_W       = 6;
	localparam int DQ_DEPTH   = 4;    // deferred read queue entries
	localparam int MB_DEPTH   = 4;    // mask buffers
	localparam int DQ_IDX_W   = 2;
	localparam int MB_IDX_W   = 2;

	typedef enum logic [2:0] {
		WBO_CMD_READ,
		WBO_CMD_INTERLOCKED_READ,
		WBO_CMD_OWNERSHIP_READ,
		WBO_CMD_MASKED_WRITE,
		WBO_CMD_UNLOCK_MASKED_WRITE,
		WBO_CMD_DISOWN_MASKED_WRITE,
		WBO_CMD_TAG_BAD_WRITE
	} wbo_cmd_t;

	typedef enum logic [1:0] {
		WBO_ST_FREE,
		WBO_ST_LOCKED,
		WBO_ST_OWNED,
		WBO_ST_TAGGED_BAD
	} wbo_state_t;

	typedef enum logic [1:0] {
		WBO_RSP_NONE,
		WBO_RSP_GOOD_READ_DATA,
		WBO_RSP_READ_ERROR_RESPONSE,
		WBO_RSP_LOCK_RESPONSE
	} wbo_rsp_t;

	// function code driven with the lock response
	localparam logic [3:0] LOCK_FUNC_CODE = 4'h4;
	localparam logic [1:0] STATE_RESET    = 2'h0;
	localparam logic [BYTES-1:0] MASK_NONE = 32'h0000_0000;
endpackage
`default_nettype wire

//--- src/wbo_bus_if.sv
// interface: command and response path between commander and memory
`default_nettype none
interface wbo_bus_if;
	import wbo_pkg::*;
	logic              cmd_valid;
	logic              cmd_ready;
	wbo_cmd_t          cmd;
	logic [ADDR_W-1:0] cmd_addr;
	logic [ID_W-1:0]   cmd_id;
	logic [BYTES-1:0]  cmd_mask;
	logic [255:0]      cmd_data;
	logic              cmd_io;
	logic              rsp_valid;
	wbo_rsp_t          rsp;
	logic [3:0]        rsp_func;
	logic [ID_W-1:0]   rsp_id;
	logic [255:0]      rsp_data;
	logic              err_flag;

	modport mem (input cmd_valid, cmd, cmd_addr, cmd_id, cmd_mask,
		cmd_data, cmd_io, output cmd_ready, rsp_valid, rsp, rsp_func,
		rsp_id, rsp_data, err_flag);
	modport cmdr (output cmd_valid, cmd, cmd_addr, cmd_id, cmd_mask,
		cmd_data, cmd_io, input cmd_ready, rsp_valid, rsp, rsp_func,
		rsp_id, rsp_data, err_flag);
endinterface
`default_nettype wire

//--- src/wbo_snoop.sv
// module: cache line snoop classification and action choice
`default_nettype none
module wbo_snoop
	import wbo_pkg::*;
(
	// snooped reference
	input  wire logic     hit_valid_i,
	input  wire logic     hit_dirty_i,
	input  wire wbo_cmd_t cmd_i,
	// chosen action
	output logic          write_back_o,
	output logic          invalidate_o,
	output logic          snoop_err_o
);
	logic is_dw;
	logic inv_cmd;
	// classify and pick action for a hit
	assign is_dw   = (cmd_i == WBO_CMD_DISOWN_MASKED_WRITE);
	assign inv_cmd = (cmd_i == WBO_CMD_OWNERSHIP_READ) ||
		(cmd_i == WBO_CMD_MASKED_WRITE) ||
		(cmd_i == WBO_CMD_UNLOCK_MASKED_WRITE);
	assign write_back_o = hit_valid_i && hit_dirty_i && !is_dw;
	assign invalidate_o = hit_valid_i && inv_cmd;
	assign snoop_err_o  = hit_valid_i && is_dw;
endmodule
`default_nettype wire

//--- src/wbo_memory.sv
// module: memory end keeping block state, deferred reads and mask buffers
// Behaviour
// - two-bit state per 32-byte block
// - at most one owner per block
// - read gives data, deferred if owned, error
// - interlocked read locks free, else lock/error
// - ownership read owns free, else lock/error
// - masked write always, state unchanged
// - unlock, disown, tag-bad writes; flag errors
// - owner releases only by disown or tag-bad
// - owner writes back on snooped reference
// - owned-block read goes to deferred queue
// - disown writes first, then services all matching deferred reads
// - owned-block masked write stored plus mask buffered
// - disown skips buffered bytes, frees buffer
// - mask buffer holds 32 byte bits
// - masked writes in order, masks ORed
// - caching node ignores a miss
// - clean-hit actions per command
// - dirty-hit actions per command
// - I/O never ownership reads or disowns
// - I/O writes complete, I/O reads deferred
// - lock response uses function code 0100
// - lock/own state set at command receipt
`default_nettype none
module wbo_memory
	import wbo_pkg::*;
(
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic reset_n_i,
	// bus
	wbo_bus_if.mem    bus
);
	import wbo_pkg::*;
	//----------------------------------------
	// storage
	//----------------------------------------
	wbo_state_t             blk_state [BLOCKS];
	logic [255:0]           blk_data  [BLOCKS];
	logic                   dq_valid  [DQ_DEPTH];
	logic [BLK_IDX_W-1:0]   dq_blk    [DQ_DEPTH];
	logic [ID_W-1:0]        dq_id     [DQ_DEPTH];
	logic                   mb_valid  [MB_DEPTH];
	logic [BLK_IDX_W-1:0]   mb_blk    [MB_DEPTH];
	logic [BYTES-1:0]       mb_mask   [MB_DEPTH];
	logic                   draining;       // servicing deferred reads
	logic [BLK_IDX_W-1:0]   drain_blk;
	logic                   rsp_valid;
	wbo_rsp_t               rsp;
	logic [ID_W-1:0]        rsp_id;
	logic [255:0]           rsp_data;
	logic                   err_flag;

	//----------------------------------------
	// decode
	//----------------------------------------
	function automatic logic [255:0] merge(input logic [255:0] old_d,
		input logic [255:0] new_d, input logic [BYTES-1:0] m);
		logic [255:0] r;
		r = old_d;
		for (int b = 0; b < BYTES; b++) begin
			if (m[b]) begin
				r[b*8 +: 8] = new_d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [BLK_IDX_W-1:0] blk;
	wbo_state_t           cur;
	logic                 take;
	logic                 dq_hit;
	logic [DQ_IDX_W-1:0]  dq_hit_idx;
	logic                 dq_free;
	logic [DQ_IDX_W-1:0]  dq_free_idx;
	logic                 mb_hit;
	logic [MB_IDX_W-1:0]  mb_hit_idx;
	logic                 mb_free;
	logic [MB_IDX_W-1:0]  mb_free_idx;
	logic                 need_dq;
	logic                 need_mb;

	assign blk = bus.cmd_addr[BLK_IDX_W-1:0];
	assign cur = blk_state[blk];
	assign need_dq = (bus.cmd == WBO_CMD_READ) && (cur == WBO_ST_OWNED);
	assign need_mb = (bus.cmd == WBO_CMD_MASKED_WRITE) &&
		(cur == WBO_ST_OWNED) && !mb_hit;

	// search deferred queue and mask buffers
	always_comb begin
		dq_hit = 1'b0;
		dq_hit_idx = '0;
		dq_free = 1'b0;
		dq_free_idx = '0;
		mb_hit = 1'b0;
		mb_hit_idx = '0;
		mb_free = 1'b0;
		mb_free_idx = '0;
		for (int i = DQ_DEPTH - 1; i >= 0; i--) begin
			if (dq_valid[i] && dq_blk[i] == drain_blk) begin
				dq_hit = 1'b1;
				dq_hit_idx = DQ_IDX_W'(i);
			end
			if (!dq_valid[i]) begin
				dq_free = 1'b1;
				dq_free_idx = DQ_IDX_W'(i);
			end
		end
		for (int i = MB_DEPTH - 1; i >= 0; i--) begin
			if (mb_valid[i] && mb_blk[i] == blk) begin
				mb_hit = 1'b1;
				mb_hit_idx = MB_IDX_W'(i);
			end
			if (!mb_valid[i]) begin
				mb_free = 1'b1;
				mb_free_idx = MB_IDX_W'(i);
			end
		end
	end

	// stall while draining or when a needed slot is missing
	assign bus.cmd_ready = !draining && !(need_dq && !dq_free) &&
		!(need_mb && !mb_free);
	assign take = bus.cmd_valid && bus.cmd_ready;

	assign bus.rsp_valid = rsp_valid;
	assign bus.rsp       = rsp;
	assign bus.rsp_func  = (rsp == WBO_RSP_LOCK_RESPONSE) ?
		LOCK_FUNC_CODE : 4'h0;
	assign bus.rsp_id    = rsp_id;
	assign bus.rsp_data  = rsp_data;
	assign bus.err_flag  = err_flag;

	//----------------------------------------
	// command processing
	//----------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < BLOCKS; i++) begin
				blk_state[i] <= wbo_state_t'(STATE_RESET);
				blk_data[i]  <= '0;
			end
			for (int i = 0; i < DQ_DEPTH; i++) begin
				dq_valid[i] <= 1'b0;
				dq_blk[i]   <= '0;
				dq_id[i]    <= '0;
			end
			for (int i = 0; i < MB_DEPTH; i++) begin
				mb_valid[i] <= 1'b0;
				mb_blk[i]   <= '0;
				mb_mask[i]  <= MASK_NONE;
			end
			draining  <= 1'b0;
			drain_blk <= '0;
			rsp_valid <= 1'b0;
			rsp       <= WBO_RSP_NONE;
			rsp_id    <= '0;
			rsp_data  <= '0;
			err_flag  <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			rsp       <= WBO_RSP_NONE;
			err_flag  <= 1'b0;
			if (draining) begin
				// answer matching deferred reads one per cycle
				if (dq_hit) begin
					dq_valid[dq_hit_idx] <= 1'b0;
					rsp_valid <= 1'b1;
					rsp       <= WBO_RSP_GOOD_READ_DATA;
					rsp_id    <= dq_id[dq_hit_idx];
					rsp_data  <= blk_data[drain_blk];
				end else begin
					draining <= 1'b0;
				end
			end else if (take) begin
				rsp_id <= bus.cmd_id;
				case (bus.cmd)
				WBO_CMD_READ, WBO_CMD_INTERLOCKED_READ,
				WBO_CMD_OWNERSHIP_READ: begin
					if (cur == WBO_ST_TAGGED_BAD) begin
						rsp_valid <= 1'b1;
						rsp <= WBO_RSP_READ_ERROR_RESPONSE;
					end else if (bus.cmd == WBO_CMD_READ) begin
						if (cur == WBO_ST_OWNED) begin
							dq_valid[dq_free_idx] <= 1'b1;
							dq_blk[dq_free_idx]   <= blk;
							dq_id[dq_free_idx]    <= bus.cmd_id;
						end else begin
							rsp_valid <= 1'b1;
							rsp      <= WBO_RSP_GOOD_READ_DATA;
							rsp_data <= blk_data[blk];
						end
					end else if (cur == WBO_ST_FREE) begin
						rsp_valid <= 1'b1;
						rsp       <= WBO_RSP_GOOD_READ_DATA;
						rsp_data  <= blk_data[blk];
						blk_state[blk] <= (bus.cmd == WBO_CMD_OWNERSHIP_READ) ?
							WBO_ST_OWNED : WBO_ST_LOCKED;
					end else begin
						rsp_valid <= 1'b1;
						rsp <= WBO_RSP_LOCK_RESPONSE;
					end
				end
				WBO_CMD_MASKED_WRITE: begin
					blk_data[blk] <= merge(blk_data[blk], bus.cmd_data,
						bus.cmd_mask);
					if (cur == WBO_ST_OWNED) begin
						if (mb_hit) begin
							mb_mask[mb_hit_idx] <= mb_mask[mb_hit_idx] |
								bus.cmd_mask;
						end else begin
							mb_valid[mb_free_idx] <= 1'b1;
							mb_blk[mb_free_idx]   <= blk;
							mb_mask[mb_free_idx]  <= bus.cmd_mask;
						end
					end
				end
				WBO_CMD_UNLOCK_MASKED_WRITE: begin
					blk_data[blk] <= merge(blk_data[blk], bus.cmd_data,
						bus.cmd_mask);
					if (cur == WBO_ST_LOCKED) begin
						blk_state[blk] <= WBO_ST_FREE;
					end else begin
						err_flag <= 1'b1;
					end
				end
				WBO_CMD_DISOWN_MASKED_WRITE: begin
					// buffered bytes are kept, then reads drain
					blk_data[blk] <= merge(blk_data[blk], bus.cmd_data,
						bus.cmd_mask & ~(mb_hit ? mb_mask[mb_hit_idx] :
						MASK_NONE));
					if (mb_hit) begin
						mb_valid[mb_hit_idx] <= 1'b0;
					end
					if (cur != WBO_ST_TAGGED_BAD) begin
						blk_state[blk] <= WBO_ST_FREE;
					end
					err_flag  <= (cur != WBO_ST_OWNED);
					draining  <= 1'b1;
					drain_blk <= blk;
				end
				WBO_CMD_TAG_BAD_WRITE: begin
					blk_data[blk] <= merge(blk_data[blk], bus.cmd_data,
						bus.cmd_mask);
					if (cur != WBO_ST_TAGGED_BAD) begin
						blk_state[blk] <= WBO_ST_TAGGED_BAD;
					end
					if (mb_hit) begin
						mb_valid[mb_hit_idx] <= 1'b0;
					end
					err_flag  <= (cur != WBO_ST_OWNED);
					draining  <= 1'b1;
					drain_blk <= blk;
				end
				default: begin
					err_flag <= 1'b1;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- src/wbo_commander.sv
// module: caching or I/O commander end with snooping and write-back
`default_nettype none
module wbo_commander
	import wbo_pkg::*;
(
	// clock and reset
	input  wire logic              mclk_i,
	input  wire logic              reset_n_i,
	// user request
	input  wire logic              req_valid_i,
	input  wire wbo_cmd_t          req_cmd_i,
	input  wire logic [ADDR_W-1:0] req_addr_i,
	input  wire logic [BYTES-1:0]  req_mask_i,
	input  wire logic [255:0]      req_data_i,
	input  wire logic [ID_W-1:0]   node_id_i,
	input  wire logic              io_node_i,
	output logic                   req_ready_o,
	// snooped reference and cache line state
	input  wire logic              snp_valid_i,
	input  wire wbo_cmd_t          snp_cmd_i,
	input  wire logic              hit_valid_i,
	input  wire logic              hit_dirty_i,
	input  wire logic [ADDR_W-1:0] snp_addr_i,
	input  wire logic [255:0]      line_data_i,
	output logic                   invalidate_o,
	output logic                   snoop_err_o,
	// response
	output logic                   rsp_valid_o,
	output wbo_rsp_t               rsp_o,
	output logic [255:0]           rsp_data_o,
	// bus
	wbo_bus_if.cmdr                bus
);
	import wbo_pkg::*;
	logic wb_need;
	logic inv;
	logic serr;
	logic blocked;
	logic wb_pend;
	logic [ADDR_W-1:0] wb_addr;
	logic [255:0]      wb_data;
	logic [255:0]      rdata;

	wbo_snoop wbo_snoop_inst (
		.hit_valid_i  (hit_valid_i && snp_valid_i),
		.hit_dirty_i  (hit_dirty_i),
		.cmd_i        (snp_cmd_i),
		.write_back_o (wb_need),
		.invalidate_o (inv),
		.snoop_err_o  (serr)
	);

	// I/O nodes may not issue ownership reads or disowns
	assign blocked = io_node_i && (req_cmd_i == WBO_CMD_OWNERSHIP_READ ||
		req_cmd_i == WBO_CMD_DISOWN_MASKED_WRITE);
	assign invalidate_o  = inv;
	assign snoop_err_o   = serr;
	assign bus.cmd_valid = wb_pend || (req_valid_i && !blocked);
	assign bus.cmd = wb_pend ? WBO_CMD_DISOWN_MASKED_WRITE : req_cmd_i;
	assign bus.cmd_addr  = wb_pend ? wb_addr : req_addr_i;
	assign bus.cmd_id    = node_id_i;
	assign bus.cmd_mask  = wb_pend ? {BYTES{1'b1}} : req_mask_i;
	assign bus.cmd_data  = wb_pend ? wb_data : req_data_i;
	assign bus.cmd_io    = io_node_i;
	assign req_ready_o   = !wb_pend && (blocked || bus.cmd_ready);
	assign rsp_valid_o   = bus.rsp_valid && bus.rsp_id == node_id_i;
	assign rsp_o         = bus.rsp;
	assign rsp_data_o    = rdata;

	// write-back of a dirty line takes priority over the user
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wb_pend <= 1'b0;
			wb_addr <= '0;
			wb_data <= '0;
			rdata   <= '0;
		end else begin
			if (wb_pend && bus.cmd_ready) begin
				wb_pend <= 1'b0;
			end
			if (wb_need && !wb_pend) begin
				wb_pend <= 1'b1;
				wb_addr <= snp_addr_i;
				wb_data <= line_data_i;
			end
			if (bus.rsp_valid) begin
				rdata <= bus.rsp_data;
			end
		end
	end
endmodule
`default_nettype wire

//--- test/wbo_chk.sv
// checker: answer, block state and error rules seen on the bus
`default_nettype none
module wbo_chk
	import wbo_pkg::*;
(
	// clock and reset
	input wire logic              mclk_i,
	input wire logic              reset_n_i,
	// command side
	input wire logic              cmd_valid,
	input wire logic              cmd_ready,
	input wire wbo_cmd_t          cmd,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [ID_W-1:0]   cmd_id,
	// answer side
	input wire logic              rsp_valid,
	input wire wbo_rsp_t          rsp,
	input wire logic [3:0]        rsp_func,
	input wire logic [ID_W-1:0]   rsp_id,
	input wire logic              err_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	import wbo_pkg::*;
	wbo_state_t st [BLOCKS];
	wbo_state_t cur;
	wbo_state_t next_st;
	logic       pend;
	logic       take;
	logic       rdx;
	logic       rel;
	//-----------------------
	// shadow of block states
	//-----------------------
	assign take = cmd_valid && cmd_ready;
	assign cur  = st[cmd_addr[BLK_IDX_W-1:0]];
	assign rdx  = cmd inside {WBO_CMD_INTERLOCKED_READ,
		WBO_CMD_OWNERSHIP_READ};
	assign rel  = cmd inside {WBO_CMD_DISOWN_MASKED_WRITE,
		WBO_CMD_TAG_BAD_WRITE};
	// bad blocks stay bad; disown frees the block, tag-bad write tags it bad
	assign next_st = (cur == WBO_ST_TAGGED_BAD) ? cur :
		(cmd == WBO_CMD_TAG_BAD_WRITE) ? WBO_ST_TAGGED_BAD :
		(cmd == WBO_CMD_DISOWN_MASKED_WRITE) ? WBO_ST_FREE :
		(cmd == WBO_CMD_UNLOCK_MASKED_WRITE && cur == WBO_ST_LOCKED) ?
		WBO_ST_FREE : (cur != WBO_ST_FREE) ? cur :
		(cmd == WBO_CMD_INTERLOCKED_READ) ? WBO_ST_LOCKED :
		(cmd == WBO_CMD_OWNERSHIP_READ) ? WBO_ST_OWNED : cur;
	// state update and deferred read marker
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st   <= '{default: WBO_ST_FREE};
			pend <= 1'b0;
		end else if (take) begin
			st[cmd_addr[BLK_IDX_W-1:0]] <= next_st;
			pend <= rel ? 1'b0 :
				pend || (cmd == WBO_CMD_READ && cur == WBO_ST_OWNED);
		end
	end
	//-----------
	// assertions
	//-----------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_take(wbo_cmd_t c, wbo_state_t s);
		take && cmd == c && cur == s;
	endsequence
	sequence s_ans(wbo_rsp_t r);
		rsp_valid && rsp == r;
	endsequence
	AST_READ_GOOD: assert property (
		take && cmd == WBO_CMD_READ && cur inside {WBO_ST_FREE, WBO_ST_LOCKED}
		|=> s_ans(WBO_RSP_GOOD_READ_DATA) ##0 rsp_id == $past(cmd_id))
		else $error("read of free block not answered good");
	AST_GRANT: assert property (
		s_take(WBO_CMD_INTERLOCKED_READ, WBO_ST_FREE) or
		s_take(WBO_CMD_OWNERSHIP_READ, WBO_ST_FREE)
		|=> s_ans(WBO_RSP_GOOD_READ_DATA))
		else $error("claim of free block not answered good");
	AST_DENY: assert property (
		take && rdx && cur inside {WBO_ST_LOCKED, WBO_ST_OWNED}
		|=> s_ans(WBO_RSP_LOCK_RESPONSE))
		else $error("claim of held block not denied");
	AST_BAD_READ: assert property (
		take && (rdx || cmd == WBO_CMD_READ) && cur == WBO_ST_TAGGED_BAD
		|=> s_ans(WBO_RSP_READ_ERROR_RESPONSE))
		else $error("read of bad block not answered with error");
	AST_DEFER: assert property (
		s_take(WBO_CMD_READ, WBO_ST_OWNED) |=> !rsp_valid)
		else $error("read of owned block answered at once");
	AST_DRAIN: assert property (
		take && rel && pend
		|=> !cmd_ready ##1 (s_ans(WBO_RSP_GOOD_READ_DATA) ##0 !cmd_ready))
		else $error("deferred read not served after release");
	AST_LOCK_FUNC: assert property (
		rsp_valid && rsp == WBO_RSP_LOCK_RESPONSE |-> rsp_func == 4'h4)
		else $error("lock answer without its function code");
	AST_UNLOCK_ERR: assert property (
		take && cmd == WBO_CMD_UNLOCK_MASKED_WRITE && cur != WBO_ST_LOCKED
		|=> err_flag)
		else $error("unlock of unlocked block not flagged");
	AST_MW_QUIET: assert property (
		take && cmd == WBO_CMD_MASKED_WRITE |=> !err_flag && !rsp_valid)
		else $error("masked write flagged or answered");
endmodule
`default_nettype wire

//--- test/tb_wb_cache_block_ownership.sv
// testbench: memory and commander ends joined on the bus
`default_nettype none
module tb_wb_cache_block_ownership;
	timeunit 1ns;
	timeprecision 1ns;
	import wbo_pkg::*;
	localparam wbo_cmd_t C_RD = WBO_CMD_READ;
	localparam wbo_cmd_t C_IR = WBO_CMD_INTERLOCKED_READ;
	localparam wbo_cmd_t C_OR = WBO_CMD_OWNERSHIP_READ;
	localparam wbo_cmd_t C_MW = WBO_CMD_MASKED_WRITE;
	localparam wbo_cmd_t C_UW = WBO_CMD_UNLOCK_MASKED_WRITE;
	localparam wbo_cmd_t C_DW = WBO_CMD_DISOWN_MASKED_WRITE;
	localparam wbo_cmd_t C_TB = WBO_CMD_TAG_BAD_WRITE;
	localparam wbo_rsp_t R_G  = WBO_RSP_GOOD_READ_DATA;
	localparam wbo_rsp_t R_E  = WBO_RSP_READ_ERROR_RESPONSE;
	localparam wbo_rsp_t R_L  = WBO_RSP_LOCK_RESPONSE;
	localparam logic [255:0] DA = {32{8'hA1}};
	localparam logic [255:0] DB = {32{8'hB2}};
	localparam logic [255:0] LN = {32{8'h11}};
	localparam logic [255:0] W1 = {32{8'h22}};
	localparam logic [255:0] W2 = {32{8'h33}};
	localparam logic [255:0] MX = {{24{8'h11}}, {6{8'h33}}, {2{8'h22}}};
	localparam logic [31:0]  FL = 32'hFFFF_FFFF;
	logic         mclk_i    = 1'b0;
	logic         reset_n_i = 1'b0;
	logic         rq_valid  = 1'b0;
	wbo_cmd_t     rq_cmd    = WBO_CMD_READ;
	logic [3:0]   rq_blk    = 4'h0;
	logic [31:0]  rq_mask   = 32'h0;
	logic [255:0] rq_data   = 256'h0;
	logic         io        = 1'b0;
	logic         snp       = 1'b0;
	wbo_cmd_t     snp_cmd   = WBO_CMD_READ;
	logic         hv        = 1'b0;
	logic         hd        = 1'b0;
	logic         rq_ready;
	logic         inv;
	logic         serr;
	logic         rv;
	wbo_rsp_t     rs;
	logic [255:0] rdd;
	int           mismatches = 0;
	int           n_compared = 0;
	int           errs = 0;
	int           nrsp = 0;
	int           cyc  = 0;
	//------------------
	// design under test
	//------------------
	always #5 mclk_i = ~mclk_i;
	wbo_bus_if bus ();
	wbo_memory wbo_memory_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.bus(bus));
	wbo_commander wbo_commander_inst (.mclk_i(mclk_i),
		.reset_n_i(reset_n_i), .req_valid_i(rq_valid), .req_cmd_i(rq_cmd),
		.req_addr_i({8'h00, rq_blk}), .req_mask_i(rq_mask),
		.req_data_i(rq_data), .node_id_i(6'h05), .io_node_i(io),
		.req_ready_o(rq_ready), .snp_valid_i(snp), .snp_cmd_i(snp_cmd),
		.hit_valid_i(hv), .hit_dirty_i(hd), .snp_addr_i(12'h002),
		.line_data_i(LN), .invalidate_o(inv), .snoop_err_o(serr),
		.rsp_valid_o(rv), .rsp_o(rs), .rsp_data_o(rdd), .bus(bus));
	wbo_chk wbo_chk_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.cmd_valid(bus.cmd_valid), .cmd_ready(bus.cmd_ready),
		.cmd(bus.cmd), .cmd_addr(bus.cmd_addr), .cmd_id(bus.cmd_id),
		.rsp_valid(bus.rsp_valid), .rsp(bus.rsp), .rsp_func(bus.rsp_func),
		.rsp_id(bus.rsp_id), .err_flag(bus.err_flag));
	// count error pulses and answers; cut a hang short
	always @(posedge mclk_i) begin
		if (bus.err_flag === 1'b1)
			errs++;
		if (bus.rsp_valid === 1'b1)
			nrsp++;
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	//------
	// tasks
	//------
	task automatic check(input logic [255:0] got, input logic [255:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// hold a request until the commander accepts it
	task automatic send(input wbo_cmd_t c, input logic [3:0] b,
		input logic [31:0] m, input logic [255:0] d);
		int n;
		@(negedge mclk_i);
		rq_valid = 1'b1;
		rq_cmd = c;
		rq_blk = b;
		rq_mask = m;
		rq_data = d;
		n = 0;
		#4;
		while (rq_ready !== 1'b1 && n < 60) begin
			@(negedge mclk_i);
			#4;
			n++;
		end
		check(n < 60, 1'b1);
		@(negedge mclk_i);
		rq_valid = 1'b0;
	endtask
	task automatic get(output wbo_rsp_t r, output logic [255:0] d);
		int n;
		n = 0;
		while (rv !== 1'b1 && n < 40) begin
			@(negedge mclk_i);
			n++;
		end
		r = rs;
		@(negedge mclk_i);
		d = rdd;
	endtask
	task automatic rd(input wbo_cmd_t c, input logic [3:0] b,
		input wbo_rsp_t er, input logic [255:0] ed);
		wbo_rsp_t     r;
		logic [255:0] d;
		send(c, b, FL, 256'h0);
		get(r, d);
		check(r, er);
		if (er == R_G)
			check(d, ed);
	endtask
	task automatic wr(input wbo_cmd_t c, input logic [3:0] b,
		input logic [31:0] m, input logic [255:0] d);
		send(c, b, m, d);
		repeat (2) @(negedge mclk_i);
	endtask
	task automatic end_sim;
		if (mismatches == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	//---------------
	// main sequence
	//---------------
	initial begin
		wbo_rsp_t     r;
		logic [255:0] d;
		wbo_cmd_t     c;
		int           n;
		int           ee;
		logic         e;
		repeat (5) @(posedge mclk_i);
		@(negedge mclk_i);
		reset_n_i = 1'b1;
		check(bus.cmd_ready, 1'b1);
		// lock, deny, unlock
		wr(C_MW, 4'h1, FL, DA);
		rd(C_IR, 4'h1, R_G, DA);
		rd(C_IR, 4'h1, R_L, DA);
		rd(C_OR, 4'h1, R_L, DA);
		rd(C_RD, 4'h1, R_G, DA);
		wr(C_UW, 4'h1, FL, DB);
		ee = 1;
		wr(C_UW, 4'h1, 32'h0000_00FF, DA);
		rd(C_RD, 4'h1, R_G, {DB[255:64], DA[63:0]});
		check(errs, ee);
		// owned block: buffered writes, deferred read, snooped write-back
		wr(C_MW, 4'h2, FL, DB);
		rd(C_OR, 4'h2, R_G, DB);
		rd(C_IR, 4'h2, R_L, DA);
		wr(C_MW, 4'h2, 32'h0000_000F, W1);
		io = 1'b1;
		n = nrsp;
		wr(C_OR, 4'h2, FL, DA);
		wr(C_MW, 4'h2, 32'h0000_00FC, W2);
		send(C_RD, 4'h2, FL, 256'h0);
		repeat (3) @(negedge mclk_i);
		check(nrsp, n);
		io = 1'b0;
		hv = 1'b1;
		hd = 1'b1;
		snp = 1'b1;
		#2;
		check(inv, 1'b0);
		@(negedge mclk_i);
		snp = 1'b0;
		get(r, d);
		check(r, R_G);
		check(d, MX);
		rd(C_OR, 4'h2, R_G, MX);
		wr(C_DW, 4'h2, FL, DB);
		rd(C_RD, 4'h2, R_G, DB);
		// tagged bad block
		rd(C_OR, 4'h2, R_G, DB);
		wr(C_TB, 4'h2, FL, DA);
		rd(C_RD, 4'h2, R_E, DA);
		rd(C_IR, 4'h2, R_E, DA);
		rd(C_OR, 4'h2, R_E, DA);
		wr(C_MW, 4'h2, FL, DA);
		ee = 2;
		wr(C_DW, 4'h2, FL, DA);
		rd(C_RD, 4'h2, R_E, DA);
		check(errs, ee);
		// snoop classification per command
		for (int i = 0; i < 18; i++) begin
			c = wbo_cmd_t'(i % 6);
			begin
				@(negedge mclk_i);
				snp_cmd = c;
				hv = i >= 6;
				hd = i >= 12;
				snp = 1'b1;
				#2;
				e = i >= 6 && c inside {C_OR, C_MW, C_UW};
				if (c != C_IR)
					check(inv, e);
				check(serr, i >= 6 && c == C_DW);
				@(negedge mclk_i);
				snp = 1'b0;
			end
		end
		end_sim();
	end
endmodule
`default_nettype wire
